// *** rtl/sic_pkg.sv ***
// Summary of operation
// RULE1 - Top bits 01 select cause register; read-only bit 1 leaves enables alone
// RULE2 - Read-only bit 0: return causes and load payload into enable register
// RULE3 - Bit 11 set when standby watchdog overflow gave an interrupt
// RULE4 - Bit 10 set on any change of temperature warning state
// RULE5 - Bit 9 set on any change of ground offset state
// RULE6 - Bit 8 set when a frame has other than 16 clocks
// RULE7 - Wrong-length frame without interrupt is discarded, no register changes
// RULE8 - Bit 7 set when battery monitor falling edge forced an interrupt
// RULE9 - Bit 6 set when any of three rail good indications clears
// RULE10 - Bit 5 set whenever bus failure status bits change
// RULE11 - Bits 4 and 0 are reserved and always read zero
// RULE12 - Bit 3 set on falling edge of local wake pin
// RULE13 - Bit 2 set when watchdog restart while watchdog off gave interrupt
// RULE14 - Bit 1 set when a bus wake-up event gave an interrupt
// RULE15 - Cause flags reported by a read clear at its end; all cause flags clear on every reset
// RULE16 - Events arriving during a read are kept for the next read
// RULE17 - After a read the interrupt output is released for a set interval
// RULE18 - In normal mode non-urgent interrupts signal at most once per watchdog period
// RULE19 - Interrupt output low while an unread flag is pending, except in release or while a normal-mode non-urgent flag waits for the next watchdog period
package sic_pkg;
   // Frame layout
   localparam int FRAME_BITS = 16;
   localparam int SEL_HI     = 15;
   localparam int SEL_LO     = 14;
   localparam int FB_SEL_BIT = 13;
   localparam int RO_BIT     = 12;
   localparam logic [1:0] SEL_CAUSE = 2'h1;
   localparam logic [4:0] CNT_GOOD  = 5'h10;
   localparam logic [4:0] CNT_MAX   = 5'h1F;
   // Cause bit positions
   localparam int DOG_OVF_BIT  = 11;
   localparam int OVERHEAT_BIT = 10;
   localparam int GND_OFS_BIT  = 9;
   localparam int FRAME_ERR_BIT = 8;
   localparam int BATT_BIT     = 7;
   localparam int SUPPLY_BIT   = 6;
   localparam int BUS_FAIL_BIT = 5;
   localparam int LOCAL_BIT    = 3;
   localparam int DOG_RST_BIT  = 2;
   localparam int BUS_ROUSE_BIT = 1;
   // Bits 4 and 0 are reserved; 15..12 carry the frame header
   localparam logic [11:0] VALID_MASK  = 12'hFEE;
   localparam logic [11:0] URGENT_MASK = 12'h984;
   localparam logic [11:0] CAUSE_RST   = 12'h000;
   localparam logic [11:0] ENABLE_RST  = 12'h000;
   localparam int BUS_FAIL_W = 4;
   // Timing
   localparam int CLK_MHZ          = 50;
   localparam int RELEASE_NS       = 1000;
   localparam int RELEASE_CYC      = (RELEASE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] REL_LOAD = 8'(RELEASE_CYC);
endpackage : sic_pkg

// *** rtl/sic_cause.sv ***
`timescale 1ns/1ps
`default_nettype none
module sic_cause (
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst,
   // Serial port pins
   input  wire logic                           sclk,
   input  wire logic                           cs_n,
   input  wire logic                           mosi,
   output logic                                miso,
   output logic                                miso_oe,
   // Event sources from device logic
   input  wire logic                           dog_overflow_evt,
   input  wire logic                           dog_restart_evt,
   input  wire logic                           bus_rouse_evt,
   input  wire logic                           temp_warning_state,
   input  wire logic                           ground_offset_state,
   input  wire logic [sic_pkg::BUS_FAIL_W-1:0] bus_fail_status,
   input  wire logic                           rail1_good,
   input  wire logic                           rail2_good,
   input  wire logic                           rail3_good,
   // Event pins
   input  wire logic                           batt_sense,
   input  wire logic                           local_wake,
   // Mode and throttle
   input  wire logic                           normal_mode,
   input  wire logic                           dog_period_tick,
   // Status outputs
   output logic [11:0]                         irq_enable,
   output logic                                irq_out_n
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: stage 0 read only by stage 1
   logic [4:0] sync0_q;
   logic [4:0] sync1_q;
   logic [4:0] prev_q;
   always_ff @(posedge clk)
   begin
      sync0_q <= {local_wake, batt_sense, mosi, cs_n, sclk};
      sync1_q <= sync0_q;
      prev_q  <= sync1_q;
   end

   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   logic batt_fall;
   logic wake_fall;
   assign sclk_rise = sync1_q[0] & ~prev_q[0];
   assign sclk_fall = ~sync1_q[0] & prev_q[0];
   assign cs_fall   = ~sync1_q[1] & prev_q[1];
   assign cs_rise   = sync1_q[1] & ~prev_q[1];
   assign batt_fall = ~sync1_q[3] & prev_q[3];
   assign wake_fall = ~sync1_q[4] & prev_q[4];

   ////////////////////////////////////////////////////////////////////////////
   // Serial frame
   logic [15:0] rx_q;
   logic [15:0] tx_q;
   logic [4:0]  cnt_q;
   logic [11:0] snap_q;
   logic [11:0] cause_q;
   logic [11:0] en_q;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rx_q    <= 16'h0000;
         tx_q    <= 16'h0000;
         cnt_q   <= 5'h00;
         snap_q  <= 12'h000;
         miso    <= 1'b0;
         miso_oe <= 1'b0;
      end
      else
      begin
         miso_oe <= ~sync1_q[1];
         if (cs_fall)
         begin
            // Snapshot fixes what this read reports and later clears
            snap_q <= cause_q;
            // Bit 15 is shown at select, so the shifter starts at bit 14
            tx_q   <= {3'h0, cause_q, 1'b0};
            miso   <= 1'b0;
            cnt_q  <= 5'h00;
         end
         else if (!sync1_q[1])
         begin
            if (sclk_rise)
            begin
               rx_q  <= {rx_q[14:0], sync1_q[2]};
               cnt_q <= (cnt_q == sic_pkg::CNT_MAX) ? cnt_q : cnt_q + 5'h01;
            end
            if (sclk_fall)
            begin
               miso <= tx_q[15];
               tx_q <= {tx_q[14:0], 1'b0};
            end
         end
      end
   end

   logic frame_ok;
   logic frame_bad;
   logic sel_cause;
   logic rd_done;
   logic wr_en;
   assign frame_ok  = cs_rise && (cnt_q == sic_pkg::CNT_GOOD);
   assign frame_bad = cs_rise && (cnt_q != sic_pkg::CNT_GOOD);
   assign sel_cause = rx_q[sic_pkg::SEL_HI:sic_pkg::SEL_LO] == sic_pkg::SEL_CAUSE;
   assign rd_done   = frame_ok && sel_cause;                                         // [RULE1]
   assign wr_en     = rd_done && !rx_q[sic_pkg::RO_BIT];                             // [RULE2]

   ////////////////////////////////////////////////////////////////////////////
   // Enable register
   always_ff @(posedge clk)
   begin
      if (rst)
         en_q <= sic_pkg::ENABLE_RST;
      else if (wr_en)
         en_q <= rx_q[11:0] & sic_pkg::VALID_MASK;                                    // [RULE2]
      else if (dog_overflow_evt)
         // Overflow interrupt must be re-armed by software every time
         en_q[sic_pkg::DOG_OVF_BIT] <= 1'b0;
   end
   assign irq_enable = en_q;

   ////////////////////////////////////////////////////////////////////////////
   // Event detection
   logic                          temp_q;
   logic                          gnd_q;
   logic [sic_pkg::BUS_FAIL_W-1:0] busf_q;
   logic [2:0]                    rails_q;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         temp_q  <= 1'b0;
         gnd_q   <= 1'b0;
         busf_q  <= '0;
         rails_q <= 3'h0;
      end
      else
      begin
         temp_q  <= temp_warning_state;
         gnd_q   <= ground_offset_state;
         busf_q  <= bus_fail_status;
         rails_q <= {rail3_good, rail2_good, rail1_good};
      end
   end

   logic [11:0] raw_evt;
   always_comb
   begin
      raw_evt                            = 12'h000;
      raw_evt[sic_pkg::DOG_OVF_BIT]      = dog_overflow_evt;                         // [RULE3]
      raw_evt[sic_pkg::OVERHEAT_BIT]     = temp_warning_state != temp_q;             // [RULE4]
      raw_evt[sic_pkg::GND_OFS_BIT]      = ground_offset_state != gnd_q;             // [RULE5]
      raw_evt[sic_pkg::FRAME_ERR_BIT]    = frame_bad;                                // [RULE6]
      raw_evt[sic_pkg::BATT_BIT]         = batt_fall;                                // [RULE8]
      raw_evt[sic_pkg::SUPPLY_BIT]       = |(rails_q & ~{rail3_good, rail2_good, rail1_good}); // [RULE9]
      raw_evt[sic_pkg::BUS_FAIL_BIT]     = bus_fail_status != busf_q;                // [RULE10]
      raw_evt[sic_pkg::LOCAL_BIT]        = wake_fall;                                // [RULE12]
      raw_evt[sic_pkg::DOG_RST_BIT]      = dog_restart_evt;                          // [RULE13]
      raw_evt[sic_pkg::BUS_ROUSE_BIT]    = bus_rouse_evt;                            // [RULE14]
   end

   // A wrong-length frame with its enable clear raises nothing and changes nothing
   logic [11:0] set_vec;
   assign set_vec = raw_evt & en_q & sic_pkg::VALID_MASK;                            // [RULE7] [RULE11]

   ////////////////////////////////////////////////////////////////////////////
   // Cause flags: set wins over clear, only snapshotted bits clear
   logic [11:0] cause_d;
   genvar gi;
   generate
      for (gi = 0; gi < 12; gi++)
      begin : g_cause
         always_comb
         begin
            cause_d[gi] = set_vec[gi] | (cause_q[gi] & ~(rd_done & snap_q[gi]));    // [RULE15] [RULE16]
         end
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (rst)
         cause_q <= sic_pkg::CAUSE_RST;                                               // [RULE15]
      else
         cause_q <= cause_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt output with post-read release and normal-mode throttle
   logic [7:0] rel_q;
   logic       token_q;
   logic       irq_q;
   logic       urgent;
   logic       lazy;
   logic       want;
   assign urgent = |(cause_q & sic_pkg::URGENT_MASK);
   assign lazy   = |(cause_q & ~sic_pkg::URGENT_MASK);
   assign want   = urgent || (lazy && (!normal_mode || token_q));                   // [RULE18]

   always_ff @(posedge clk)
   begin
      if (rst)
         rel_q <= 8'h00;
      else if (rd_done)
         rel_q <= sic_pkg::REL_LOAD;                                                 // [RULE17]
      else if (rel_q != 8'h00)
         rel_q <= rel_q - 8'h01;
   end

   // Token limits slow-class signalling to one per watchdog period
   always_ff @(posedge clk)
   begin
      if (rst)
         token_q <= 1'b1;
      else if (dog_period_tick)
         token_q <= 1'b1;
      else if (!irq_q && rel_q == 8'h00 && normal_mode && lazy && !urgent && token_q)
         token_q <= 1'b0;                                                            // [RULE18]
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         irq_q <= 1'b0;
      else if (rd_done || rel_q != 8'h00)
         irq_q <= 1'b0;                                                              // [RULE17]
      else if (want)
         irq_q <= 1'b1;                                                              // [RULE19]
   end
   assign irq_out_n = ~irq_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_read_end;
      rd_done;
   endsequence

   a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
      cause_q[4] == 1'b0 && cause_q[0] == 1'b0)                                       // [RULE11]
      else $error("reserved cause bit set");
   a_read_clears: assert property (@(posedge clk) disable iff (rst)
      s_read_end |=> ((cause_q & $past(snap_q)) == ($past(set_vec) & $past(snap_q)))) // [RULE15]
      else $error("read did not clear reported flags");
   a_event_kept: assert property (@(posedge clk) disable iff (rst)
      (set_vec != 12'h000) |=> ((cause_q & $past(set_vec)) == $past(set_vec)))     // [RULE16]
      else $error("event lost");
   a_ro_keeps_en: assert property (@(posedge clk) disable iff (rst)
      rd_done && rx_q[sic_pkg::RO_BIT] |=> en_q[10:0] == $past(en_q[10:0]))        // [RULE1]
      else $error("read-only frame changed enables");
   a_write_en: assert property (@(posedge clk) disable iff (rst)
      wr_en |=> en_q == ($past(rx_q[11:0]) & sic_pkg::VALID_MASK))                  // [RULE2]
      else $error("enable write missing");
   a_bad_discard: assert property (@(posedge clk) disable iff (rst)
      frame_bad && !en_q[8] && !dog_overflow_evt |=> $stable(en_q))                // [RULE7]
      else $error("bad frame changed registers");
   a_bad_flag: assert property (@(posedge clk) disable iff (rst)
      frame_bad && en_q[8] |=> cause_q[8])                                           // [RULE6]
      else $error("frame length flag not set");
   a_temp_flag: assert property (@(posedge clk) disable iff (rst)
      $changed(temp_warning_state) && en_q[10] |=> cause_q[10])                      // [RULE4]
      else $error("temperature change not flagged");
   a_release_hold: assert property (@(posedge clk) disable iff (rst)
      s_read_end |=> irq_out_n [*8])                                                 // [RULE17]
      else $error("interrupt not released after read");
   a_irq_pending: assert property (@(posedge clk) disable iff (rst)
      !irq_out_n |-> cause_q != 12'h000)                                             // [RULE19]
      else $error("interrupt low with nothing pending");

endmodule : sic_cause
`default_nettype wire

// *** sim/sic_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module sic_host (
   // Serial port pins
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso,
   input  wire logic miso_oe
);
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // Sends n clocks MSB first; for n of 16 or more the last 16 carry the word, so a long frame looks valid
   task automatic frame(input logic [15:0] word, input int n, output logic [15:0] rx);
      rx   = 16'h0000;
      cs_n = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         mosi = word[(n - 1 - i) % 16];
         #80 sclk = 1'b1;
         rx = {rx[14:0], (miso_oe === 1'b1) ? miso : 1'bx};
         #80 sclk = 1'b0;
      end
      #80 cs_n = 1'b1;
      // Released data line flips so a stale level cannot look valid
      mosi = ~mosi;
      #200;
   endtask : frame
endmodule : sic_host
`default_nettype wire

// *** sim/tb_sic_cause.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_sic_cause;
   logic        clk, rst, sclk, cs_n, mosi, miso, miso_oe, irq_out_n;
   logic        dog_ovf, dog_rst, bus_rouse, temp, gnd, r1, r2, r3, batt, wake, normal, tick;
   logic [3:0]  bus_fail;
   logic [11:0] irq_enable;
   logic [15:0] rx;
   int          bad_count, samples_checked;

   ////////////////////////////////////////////////////////////////////////////////
   sic_cause DUT (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
      .miso_oe(miso_oe), .dog_overflow_evt(dog_ovf), .dog_restart_evt(dog_rst), .bus_rouse_evt(bus_rouse),
      .temp_warning_state(temp), .ground_offset_state(gnd), .bus_fail_status(bus_fail), .rail1_good(r1),
      .rail2_good(r2), .rail3_good(r3), .batt_sense(batt), .local_wake(wake), .normal_mode(normal),
      .dog_period_tick(tick), .irq_enable(irq_enable), .irq_out_n(irq_out_n));

   sic_host host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   // Pins move just after an edge so the synchronisers never race the host
   task automatic xfer(input logic [15:0] word, input int n, input logic [15:0] exp);
      @(posedge clk);
      #1;
      host.frame(word, n, rx);
      if (n == 16)
         check(rx, exp);
   endtask : xfer

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   task automatic end_of_test;
      if (bad_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   initial
   begin
      #200000;
      bad_count++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {rst, dog_ovf, dog_rst, bus_rouse, temp, gnd} = 6'h20;
      {r1, r2, r3, batt, wake} = 5'h1F;
      bus_fail = 4'h0;
      {normal, tick} = 2'h0;
      bad_count = 0;
      samples_checked = 0;
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      settle(4);
      check({4'h0, irq_enable}, 16'h0000);
      check({15'h0, irq_out_n}, 16'h0001);
      xfer(16'h4FFF, 16, 16'h0000);
      check({4'h0, irq_enable}, 16'h0FEE);
      xfer(16'h5000, 16, 16'h0000);
      check({4'h0, irq_enable}, 16'h0FEE);
      // Every source except the frame length check fires at once
      settle(1);
      {dog_ovf, dog_rst, bus_rouse, temp, gnd, r2, batt, wake} = 8'hF8;
      bus_fail = 4'h5;
      settle(1);
      {dog_ovf, dog_rst, bus_rouse, batt, wake} = 5'h03;
      // The release that follows the last read must run out first
      settle(50);
      check({15'h0, irq_out_n}, 16'h0000);
      check({4'h0, irq_enable}, 16'h07EE);
      xfer(16'h5000, 16, 16'h0EEE);
      xfer(16'h5000, 16, 16'h0000);
      // Short frame with its flag enabled, then a long write with it masked
      xfer(16'h5000, 15, 16'h0000);
      xfer(16'h5000, 16, 16'h0100);
      xfer(16'h4000, 16, 16'h0000);
      xfer(16'h4FFF, 17, 16'h0000);
      check({4'h0, irq_enable}, 16'h0000);
      xfer(16'h5000, 16, 16'h0000);
      // Battery drop lands after the read snapshot
      xfer(16'h4080, 16, 16'h0000);
      fork
         xfer(16'h5000, 16, 16'h0000);
         #1200 batt = 1'b0;
      join
      check({15'h0, irq_out_n}, 16'h0001);
      settle(30);
      check({15'h0, irq_out_n}, 16'h0001);
      settle(30);
      check({15'h0, irq_out_n}, 16'h0000);
      xfer(16'h5000, 16, 16'h0080);
      // Normal mode: a slow-class cause signals once per watchdog period
      normal = 1'b1;
      xfer(16'h4400, 16, 16'h0000);
      settle(1);
      temp = 1'b0;
      settle(60);
      check({15'h0, irq_out_n}, 16'h0000);
      xfer(16'h5000, 16, 16'h0400);
      settle(1);
      temp = 1'b1;
      settle(60);
      check({15'h0, irq_out_n}, 16'h0001);
      tick = 1'b1;
      settle(1);
      tick = 1'b0;
      settle(3);
      check({15'h0, irq_out_n}, 16'h0000);
      xfer(16'h5000, 16, 16'h0400);
      end_of_test();
   end
endmodule : tb_sic_cause
`default_nettype wire
